// ==== hdl/asseq_pkg.sv ====
// package: register map, fields and enumerations of the segment sequencer
package asseq_pkg;

  // register byte offsets
  localparam logic [7:0] ASSEQ_CTRL_OFS   = 8'h00;  // control bits
  localparam logic [7:0] ASSEQ_SEG_OFS    = 8'h04;  // target segment / jump
  localparam logic [7:0] ASSEQ_CMD_OFS    = 8'h08;  // command strobes
  localparam logic [7:0] ASSEQ_MARK_OFS   = 8'h0C;  // marker configuration
  localparam logic [7:0] ASSEQ_STAT_OFS   = 8'h10;  // current segment status
  localparam logic [7:0] ASSEQ_LIST_OFS   = 8'h14;  // play list write port
  localparam logic [7:0] ASSEQ_LEN_OFS    = 8'h18;  // segment lengths write port

  // control register fields
  localparam int ASSEQ_CTRL_LOADED  = 0;   // multi-segment waveform loaded
  localparam int ASSEQ_CTRL_EXTSRC  = 1;   // advance source external
  localparam int ASSEQ_CTRL_SEAMLS  = 2;   // seamless transition mode
  localparam int ASSEQ_CTRL_LISTEN  = 3;   // play list enabled
  localparam int ASSEQ_CTRL_BUILT   = 4;   // composed waveform built
  localparam int ASSEQ_CTRL_TRGSEL  = 5;   // external input select
  localparam int ASSEQ_CTRL_W       = 6;

  // command register fields (write one, self clearing)
  localparam int ASSEQ_CMD_ADV      = 0;   // internal advance
  localparam int ASSEQ_CMD_PLAY     = 1;   // playback trigger

  // marker configuration: per output 4 bits
  localparam int ASSEQ_MARK_W       = 4;
  localparam int ASSEQ_NMARK        = 3;

  // fields inside list / length ports
  localparam int ASSEQ_PORT_DATA_LSB = 0;
  localparam int ASSEQ_PORT_IDX_LSB  = 16;

  localparam logic [31:0] ASSEQ_ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0]  ASSEQ_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0]  ASSEQ_HTRANS_SEQ    = 2'b11;

  // restart marker choice
  typedef enum logic [1:0] {
    ASSEQ_RST_OFF,
    ASSEQ_RST_SEQUENCE,
    ASSEQ_RST_SEGMENT
  } asseq_rst_type;

  // general marker override choice
  typedef enum logic [1:0] {
    ASSEQ_GEN_PASS,
    ASSEQ_GEN_LOW,
    ASSEQ_GEN_HIGH
  } asseq_gen_type;

  // marker configuration for one output
  typedef struct packed {
    asseq_gen_type gen;       // general override
    logic          use_rst;   // output assigned to restart marker
    logic          seg_keep;  // take over embedded marker
  } asseq_mark_type;

  // ahb-lite request carrier
  typedef struct packed {
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [7:0]  haddr;
  } asseq_ahb_type;

endpackage

// ==== hdl/asseq_seg_timer.sv ====
// segment replay cycle counter: flags the last sample of a segment
`timescale 1ns/1ps
`default_nettype none
module asseq_seg_timer
  import asseq_pkg::*;
#(
  parameter int LEN_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             restart,    // start a new replay cycle
  input  wire logic [LEN_W-1:0] seg_len,    // samples of current segment minus one
  output logic                  cycle_end,  // last sample of the cycle
  output logic                  cycle_start // first sample of a cycle
);

  logic [LEN_W-1:0] cnt_r;  // sample position
  logic             first_r;

  // position counter, wraps at the segment length
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (restart || cycle_end) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // first sample flag after restart or wrap
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
    end else begin
      first_r <= restart || cycle_end;
    end
  end

  assign cycle_end   = !restart && (cnt_r >= seg_len);
  assign cycle_start = first_r;

endmodule
`default_nettype wire

// ==== hdl/asseq_marker_mux.sv ====
// marker priority resolution for one output connector
`timescale 1ns/1ps
`default_nettype none
module asseq_marker_mux
  import asseq_pkg::*;
(
  input  wire asseq_mark_type cfg,        // configuration of this output
  input  wire logic           seg_marker, // embedded segment marker
  input  wire logic           rst_marker, // added restart marker
  output logic                marker      // resolved level
);

  // priority: general override, then restart, then embedded marker
  always_comb begin
    marker = 1'b0;
    if (cfg.gen == ASSEQ_GEN_HIGH) begin
      marker = 1'b1;
    end else if (cfg.gen == ASSEQ_GEN_LOW) begin
      marker = 1'b0;
    end else if (cfg.use_rst) begin
      marker = rst_marker;
    end else begin
      marker = cfg.seg_keep & seg_marker;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/asseq_top.sv ====
// top of the segment sequencer: ahb-lite registers, stepping and markers
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module asseq_top
  import asseq_pkg::*;
#(
  parameter int SEG_W  = 4,    // segment index width
  parameter int LEN_W  = 16,   // segment length width
  parameter int LIST_W = 4     // play list index width
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic [1:0]               user_trig,    // external advance inputs
  input  wire logic [ASSEQ_NMARK-1:0]   seg_mark_in,  // markers from segment memory
  output logic [SEG_W-1:0]              seg_cur,      // segment being played
  output logic                          seg_start,    // pulse: segment restart
  output logic [ASSEQ_NMARK-1:0]        marker_out    // resolved markers
);

  localparam int NSEG  = 1 << SEG_W;
  localparam int NLIST = 1 << LIST_W;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [ASSEQ_CTRL_W-1:0]   ctrl_r;      // control bits
  logic [SEG_W-1:0]          tgt_r;       // target segment setting
  logic [SEG_W-1:0]          nseg_r;      // segments minus one
  logic                      jump_r;      // pending direct jump
  logic                      adv_cmd_r;   // internal advance strobe
  logic                      play_cmd_r;  // playback trigger strobe
  asseq_mark_type            mcfg_r [ASSEQ_NMARK];
  asseq_rst_type             rmode_r;     // restart marker mode
  logic [SEG_W-1:0]          list_r [NLIST];   // play list entries
  logic [LIST_W-1:0]         list_len_r;       // last list entry
  logic [LEN_W-1:0]          len_r [NSEG];     // segment lengths minus one
  logic [15:0]               fid_r [NSEG];     // source file identity
  asseq_ahb_type             req_r;       // latched address phase
  logic                      wr_pend_r;
  logic                      rd_pend_r;

  // decode one address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture; slave always ready, response okay
  logic take;
  assign take = hsel && hready && (htrans == ASSEQ_HTRANS_NONSEQ ||
                                   htrans == ASSEQ_HTRANS_SEQ);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_r     <= '0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) begin
        req_r <= '{htrans: htrans, hwrite: hwrite, hsize: hsize, haddr: haddr[7:0]};
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // register writes in the data phase
  logic cmd_wr;
  assign cmd_wr = wr_pend_r && hit(req_r.haddr, ASSEQ_CMD_OFS);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r     <= '0;
      tgt_r      <= '0;
      nseg_r     <= '0;
      rmode_r    <= ASSEQ_RST_OFF;
      list_len_r <= '0;
    end else if (wr_pend_r) begin
      if (hit(req_r.haddr, ASSEQ_CTRL_OFS)) begin
        ctrl_r <= hwdata[ASSEQ_CTRL_W-1:0];
        nseg_r <= hwdata[ASSEQ_PORT_IDX_LSB +: SEG_W];
        list_len_r <= hwdata[ASSEQ_PORT_IDX_LSB+8 +: LIST_W];
      end
      if (hit(req_r.haddr, ASSEQ_SEG_OFS)) begin
        tgt_r <= hwdata[SEG_W-1:0];
      end
      if (hit(req_r.haddr, ASSEQ_MARK_OFS)) begin
        rmode_r <= asseq_rst_type'(hwdata[ASSEQ_NMARK*ASSEQ_MARK_W +: 2]);
      end
    end
  end

  // marker configuration per output
  genvar gi;
  generate
    for (gi = 0; gi < ASSEQ_NMARK; gi++) begin : g_mcfg
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          mcfg_r[gi] <= '0;
        end else if (wr_pend_r && hit(req_r.haddr, ASSEQ_MARK_OFS)) begin
          mcfg_r[gi] <= hwdata[gi*ASSEQ_MARK_W +: ASSEQ_MARK_W];
        end
      end
    end
  endgenerate

  // play list and segment length / identity tables
  always_ff @(posedge ref_clk) begin
    if (wr_pend_r && hit(req_r.haddr, ASSEQ_LIST_OFS)) begin
      list_r[hwdata[ASSEQ_PORT_IDX_LSB +: LIST_W]] <= hwdata[SEG_W-1:0];
    end
    if (wr_pend_r && hit(req_r.haddr, ASSEQ_LEN_OFS)) begin
      len_r[hwdata[ASSEQ_PORT_IDX_LSB +: SEG_W]] <= hwdata[LEN_W-1:0];
      fid_r[hwdata[ASSEQ_PORT_IDX_LSB +: SEG_W]] <= hwdata[31:16];
    end
  end

  // command strobes and jump request, one cycle each
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_cmd_r  <= 1'b0;
      play_cmd_r <= 1'b0;
      jump_r     <= 1'b0;
    end else begin
      adv_cmd_r  <= cmd_wr && hwdata[ASSEQ_CMD_ADV];
      play_cmd_r <= cmd_wr && hwdata[ASSEQ_CMD_PLAY];
      // internal mode: writing the target jumps straight there, clamped to the last segment
      jump_r <= wr_pend_r && hit(req_r.haddr, ASSEQ_SEG_OFS) && !ctrl_r[ASSEQ_CTRL_EXTSRC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external trigger synchroniser and edge detect
  logic [1:0] trg_s1_r;
  logic [1:0] trg_s2_r;
  logic       trg_d_r;
  logic       ext_lvl;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trg_s1_r <= '0;
      trg_s2_r <= '0;
      trg_d_r  <= 1'b0;
    end else begin
      trg_s1_r <= user_trig;
      trg_s2_r <= trg_s1_r;
      trg_d_r  <= ext_lvl;
    end
  end
  assign ext_lvl = trg_s2_r[ctrl_r[ASSEQ_CTRL_TRGSEL]];

  ////////////////////////////////////////////////////////////////////////////
  // advance event merge: external and internal take the same path
  logic loaded;
  logic adv_evt;
  logic list_ok;
  assign loaded  = ctrl_r[ASSEQ_CTRL_LOADED] && (nseg_r != '0);
  assign list_ok = ctrl_r[ASSEQ_CTRL_LISTEN] && ctrl_r[ASSEQ_CTRL_BUILT]
                   && (nseg_r != '0);
  assign adv_evt = loaded && (ctrl_r[ASSEQ_CTRL_EXTSRC] ? (ext_lvl && !trg_d_r)
                                                        : adv_cmd_r);

  // seamless pending flag: one step at most
  logic pend_r;
  logic cyc_end;
  logic cyc_start;
  logic step;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
    end else if (!loaded || play_cmd_r) begin
      pend_r <= 1'b0;
    end else if (adv_evt) begin  // a new event beats the clear of a step
      pend_r <= ctrl_r[ASSEQ_CTRL_SEAMLS];
    end else if (cyc_end) begin
      pend_r <= 1'b0;
    end
  end
  // immediate steps now, seamless steps at cycle end
  assign step = loaded && (ctrl_r[ASSEQ_CTRL_SEAMLS] ? (pend_r && cyc_end) : adv_evt);

  ////////////////////////////////////////////////////////////////////////////
  // next segment selection and current segment
  logic [LIST_W-1:0] lpos_r;
  logic [SEG_W-1:0]  nxt_seg;
  always_comb begin
    if (list_ok) begin
      nxt_seg = list_r[(lpos_r == list_len_r) ? '0 : LIST_W'(lpos_r + 1'b1)];
    end else if (seg_cur == nseg_r) begin
      nxt_seg = '0;
    end else begin
      nxt_seg = SEG_W'(seg_cur + 1'b1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_cur <= '0;
      lpos_r  <= '0;
    end else if (!loaded) begin
      seg_cur <= '0;
      lpos_r  <= '0;
    end else if (play_cmd_r) begin
      seg_cur <= list_ok ? list_r[0] : '0;
      lpos_r  <= '0;
    end else if (jump_r) begin
      seg_cur <= (tgt_r > nseg_r) ? nseg_r : tgt_r;
    end else if (step) begin
      seg_cur <= nxt_seg;
      lpos_r  <= (lpos_r == list_len_r) ? '0 : LIST_W'(lpos_r + 1'b1);
    end
  end

  // segment replay timer
  logic restart;
  assign restart = play_cmd_r || jump_r || (step && !ctrl_r[ASSEQ_CTRL_SEAMLS]);
  asseq_seg_timer #(.LEN_W(LEN_W)) u_timer (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .restart     (restart),
    .seg_len     (len_r[seg_cur]),
    .cycle_end   (cyc_end),
    .cycle_start (cyc_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // restart marker: low in first sample cycle so a rising edge follows
  logic rst_mark_r;
  logic seq_start;
  assign seq_start = cyc_start && (seg_cur == (list_ok ? list_r[0] : '0));
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_mark_r <= 1'b0;
      seg_start  <= 1'b0;
    end else begin
      seg_start <= cyc_start;
      case (rmode_r)
        ASSEQ_RST_SEGMENT:  rst_mark_r <= cyc_start;
        ASSEQ_RST_SEQUENCE: rst_mark_r <= seq_start;
        default:            rst_mark_r <= 1'b0;
      endcase
    end
  end

  // marker resolution per output, registered
  logic [ASSEQ_NMARK-1:0] mk;
  generate
    for (gi = 0; gi < ASSEQ_NMARK; gi++) begin : g_mux
      asseq_marker_mux u_mux (
        .cfg        (mcfg_r[gi]),
        .seg_marker (seg_mark_in[gi]),
        .rst_marker (rst_mark_r),
        .marker     (mk[gi])
      );
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      marker_out <= '0;
    end else begin
      marker_out <= mk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: status shows current segment and its file identity
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= ASSEQ_ZERO_WORD;
    end else if (take && !hwrite) begin
      hrdata <= ASSEQ_ZERO_WORD;
      if (hit(haddr[7:0], ASSEQ_CTRL_OFS)) begin
        hrdata[ASSEQ_CTRL_W-1:0] <= ctrl_r;
      end else if (hit(haddr[7:0], ASSEQ_SEG_OFS)) begin
        hrdata[SEG_W-1:0] <= tgt_r;
      end else if (hit(haddr[7:0], ASSEQ_STAT_OFS)) begin
        hrdata[SEG_W-1:0] <= seg_cur;
        hrdata[31:16]     <= fid_r[seg_cur];
        hrdata[8]         <= pend_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wrap_last_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    step && !list_ok && !play_cmd_r && !jump_r && seg_cur == nseg_r
    |=> seg_cur == '0) else $error("no wrap after last segment");
  adv_next_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    step && !list_ok && !play_cmd_r && !jump_r && seg_cur < nseg_r
    |=> seg_cur == $past(seg_cur) + 1'b1) else $error("advance skipped");
  idle_unload_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !loaded |=> seg_cur == '0) else $error("stepping while unloaded");
  seamless_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ctrl_r[ASSEQ_CTRL_SEAMLS] && !cyc_end && !jump_r && !play_cmd_r
    |=> $stable(seg_cur)) else $error("seamless cut early");
  immediate_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loaded && !ctrl_r[ASSEQ_CTRL_SEAMLS] && adv_evt && !list_ok && !play_cmd_r && !jump_r
    |=> cyc_start && seg_cur != $past(seg_cur)) else $error("immediate advance lost");
  play_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loaded && play_cmd_r && !list_ok |=> seg_cur == '0)
    else $error("playback trigger no restart");
  restart_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rmode_r == ASSEQ_RST_SEGMENT && $stable(rmode_r) && cyc_start
    |=> rst_mark_r) else $error("restart marker missing");
  override_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mcfg_r[0].gen == ASSEQ_GEN_HIGH && $stable(mcfg_r[0]) |=> marker_out[0])
    else $error("override ignored");
  pend_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    step && ctrl_r[ASSEQ_CTRL_SEAMLS] && !adv_evt |=> !pend_r)
    else $error("extra advance queued");

endmodule
`default_nettype wire

// ==== dv/asseq_trig_model.sv ====
// far-side model: external advance trigger sources on the user connectors
`timescale 1ns/1ps
`default_nettype none
module asseq_trig_model (
  input  wire logic       ref_clk,   // sample clock
  input  wire logic       fire,      // request one trigger pulse
  input  wire logic       sel,       // connector to pulse
  input  wire logic [7:0] hold,      // pulse width in cycles
  output logic [1:0]      user_trig  // trigger connectors
);
  logic [7:0] cnt_r;  // remaining high cycles
  logic       sel_r;  // latched connector

  initial begin
    cnt_r = 8'h00;
    sel_r = 1'b0;
    user_trig = 2'b00;
  end

  // pulse only the chosen user connector, idle low otherwise
  always @(posedge ref_clk) begin
    if (fire) begin
      cnt_r <= hold;
      sel_r <= sel;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
    user_trig <= (cnt_r != 8'h00) ? (2'b01 << sel_r) : 2'b00;
  end
endmodule
`default_nettype wire

// ==== dv/asseq_top_tb_top.sv ====
// self-checking testbench of the segment sequencer
`timescale 1ns/1ps
`default_nettype none
module asseq_top_tb_top;
  import asseq_pkg::*;
  localparam logic [31:0] CNT4 = 32'h0003_0000;  // four segments
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  user_trig;
  logic [2:0]  seg_mark_in = 3'b000;
  logic [3:0]  seg_cur;
  logic        seg_start;
  logic [2:0]  marker_out;
  logic        fire = 1'b0;
  logic        fire_sel = 1'b0;
  logic [31:0] rd;
  logic        hit;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  assign hready = hreadyout;  // single slave drives the bus ready
  always #2.5 ref_clk = ~ref_clk;

  asseq_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .user_trig(user_trig),
    .seg_mark_in(seg_mark_in), .seg_cur(seg_cur), .seg_start(seg_start),
    .marker_out(marker_out));
  asseq_trig_model i_trig (.ref_clk(ref_clk), .fire(fire), .sel(fire_sel),
    .hold(8'h05), .user_trig(user_trig));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      print_verdict;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single ahb-lite transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= ASSEQ_HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : ASSEQ_ZERO_WORD;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_seg(input logic [3:0] exp, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (seg_cur === exp) break;
    end
    check({28'h000_0000, seg_cur}, {28'h000_0000, exp});
  endtask

  task automatic adv;
    ahb(1'b1, ASSEQ_CMD_OFS, 32'h0000_0001);
  endtask

  // watch marker 2 for a rising edge and seg_start for a pulse over n cycles
  task automatic watch(input int n, output logic rise, output logic pulse);
    logic prev;
    prev = 1'b1;
    rise = 1'b0;
    pulse = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (prev === 1'b0 && marker_out[2] === 1'b1) rise = 1'b1;
      if (seg_start === 1'b1) pulse = 1'b1;
      prev = marker_out[2];
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check({30'h0, hreadyout, hresp}, 32'h0000_0002);
    check({25'h0, marker_out, seg_cur}, 32'h0000_0000);
    ahb(1'b0, 8'h1C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask

  task automatic t_inactive;
    ahb(1'b1, ASSEQ_CTRL_OFS, CNT4);  // count set, not loaded
    adv();
    repeat (8) @(posedge ref_clk);
    wait_seg(4'h0, 1);
    check({28'h0, seg_cur}, 32'h0000_0000);
  endtask

  task automatic t_step;
    for (int s = 0; s < 4; s++) begin
      ahb(1'b1, ASSEQ_LEN_OFS, 32'hA500_00C7 | (s << 16));
    end
    ahb(1'b1, ASSEQ_CTRL_OFS, CNT4 | 32'h0000_0009);  // list on, not built
    for (int s = 1; s < 5; s++) begin
      adv();
      wait_seg(s % 4, 8);
    end
    ahb(1'b0, ASSEQ_STAT_OFS, 32'h0000_0000);
    check(rd, 32'hA500_0000);
  endtask

  task automatic t_jump_ext;
    ahb(1'b1, ASSEQ_CTRL_OFS, CNT4 | 32'h0000_0001);
    ahb(1'b1, ASSEQ_SEG_OFS, 32'h0000_0002);
    wait_seg(4'h2, 8);
    ahb(1'b1, ASSEQ_CTRL_OFS, CNT4 | 32'h0000_0023);
    ahb(1'b1, ASSEQ_SEG_OFS, 32'h0000_0001);
    repeat (6) @(posedge ref_clk);
    check({28'h0, seg_cur}, 32'h0000_0002);
    fire <= 1'b1;
    fire_sel <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    wait_seg(4'h3, 16);
    fire <= 1'b1;
    fire_sel <= 1'b0;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (16) @(posedge ref_clk);
    check({28'h0, seg_cur}, 32'h0000_0003);
  endtask

  task automatic t_play_seamless;
    ahb(1'b1, ASSEQ_CTRL_OFS, CNT4 | 32'h0000_0005);  // loaded, seamless transitions
    ahb(1'b1, ASSEQ_CMD_OFS, 32'h0000_0002);
    wait_seg(4'h0, 8);
    adv();
    adv();
    check({28'h0, seg_cur}, 32'h0000_0000);
    wait_seg(4'h1, 300);
    repeat (250) @(posedge ref_clk);
    check({28'h0, seg_cur}, 32'h0000_0001);
  endtask

  task automatic t_marker;
    logic st;
    ahb(1'b1, ASSEQ_CTRL_OFS, CNT4 | 32'h0000_0001);
    seg_mark_in <= 3'b111;
    ahb(1'b1, ASSEQ_MARK_OFS, 32'h0000_2218);  // high, keep, restart per segment
    repeat (4) @(posedge ref_clk);
    check({30'h0, marker_out[1:0]}, 32'h0000_0003);
    adv();
    watch(30, hit, st);
    check({31'h0, hit}, 32'h0000_0001);
    check({31'h0, st}, 32'h0000_0001);
    ahb(1'b1, ASSEQ_MARK_OFS, 32'h0000_2204);  // forced low, drop embedded
    repeat (4) @(posedge ref_clk);
    check({30'h0, marker_out[1:0]}, 32'h0000_0000);
  endtask

  // play list order 2, 0, 3 with a restart marker only at sequence start
  task automatic t_list_seq;
    logic st;
    ahb(1'b1, ASSEQ_MARK_OFS, 32'h0000_1200);  // sequence restart on output 2
    ahb(1'b1, ASSEQ_LIST_OFS, 32'h0000_0002);
    ahb(1'b1, ASSEQ_LIST_OFS, 32'h0001_0000);
    ahb(1'b1, ASSEQ_LIST_OFS, 32'h0002_0003);
    ahb(1'b1, ASSEQ_CTRL_OFS, CNT4 | 32'h0200_0019);  // loaded, list on, built
    ahb(1'b1, ASSEQ_CMD_OFS, 32'h0000_0002);
    wait_seg(4'h2, 8);
    watch(12, hit, st);
    check({31'h0, hit}, 32'h0000_0001);
    adv();
    watch(12, hit, st);
    check({30'h0, hit, st}, 32'h0000_0001);
    check({28'h0, seg_cur}, 32'h0000_0000);
    adv();
    wait_seg(4'h3, 8);
    ahb(1'b0, ASSEQ_STAT_OFS, 32'h0000_0000);
    check(rd, 32'hA503_0003);
    adv();
    wait_seg(4'h2, 8);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    t_reset();
    t_inactive();
    t_step();
    t_jump_ext();
    t_play_seamless();
    t_marker();
    t_list_seq();
    print_verdict;
  end
endmodule
`default_nettype wire
